/* File: hdl/tec_timer.sv */
// 8-bit count-up timer / event counter with preload, apb registers and irq
// assumes an apb master on pclk; ext_timer_pin is asynchronous to pclk;
// cpu_sleep comes from logic on pclk
//
// What this block does
// R1: mode bits 7:6 select none, event counting, timing or pulse width capture.
// R2: run bit 4 lets the counter advance; cleared it holds the count.
// R3: event mode counts rising pin edges when bit 3 is 0, falling when 1.
// R4: capture mode: bit 3 low counts low pulses, high counts high pulses.
// R5: prescaler bits 2:0 divide the internal clock by one up to 128.
// R6: pin edges count directly; the prescaler is not used for them.
// R7: internal timer clock is the system clock or the system clock over four.
// R8: timer mode adds one per falling edge of the prescaled internal clock.
// R9: overflow raises an interrupt request, reloads preload, keeps counting.
// R10: an overflow interrupt also requests wake-up from sleep.
// R11: the overflow interrupt reaches the processor only when its enable is set.
// R12: event mode takes its count clock from the pin, not the internal clock.
// R13: event counting continues during sleep and its overflow wakes the processor.
// R14: software selects event mode and makes the shared pin an input.
// R15: counting runs from the loaded value up to ffh, then overflows.
// R16: preload written while stopped loads the counter; while running, at overflow.
// R17: the pin is synchronised and each qualifying edge counts exactly once.
// R18: bit 5 reads zero, ignores writes; control resets to edge select only.
// R19: with no mode selected the counter never advances and never overflows.
module tec_timer
   import tec_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        ext_timer_pin,
   input  wire logic        cpu_sleep,
   output logic             timer_irq,
   output logic             wake_req
);
   logic [7:0]          ctrl_q;
   logic [7:0]          preload_q;
   logic [7:0]          count_q;
   logic [TEC_ST_W-1:0] status_q;
   logic [TEC_ST_W-1:0] mask_q;
   logic [TEC_ST_W-1:0] st_set;
   logic                cfg_div4_q;
   logic                sync1_q;
   logic                sync2_q;
   logic                pin_prev_q;
   tec_pwc_t            pwc_q;
   tec_mode_t           mode;
   logic                run;
   logic                edge_sel;
   logic                setup;
   logic                wr;
   logic                mapped;
   logic                wr_ctrl;
   logic                preload_wr;
   logic                pin_rise;
   logic                pin_fall;
   logic                ev_edge;
   logic                pwc_start;
   logic                pwc_stop;
   logic                psc_active;
   logic                tick;
   logic                inc;
   logic                ovf;
   logic                cap_done;

   assign mode     = tec_mode_t'(ctrl_q[TEC_MODE_HI:TEC_MODE_LO]); // R1
   assign run      = ctrl_q[TEC_RUN_BIT];
   assign edge_sel = ctrl_q[TEC_EDGE_BIT];

   // apb decode: pready is registered, so every access has no wait state
   assign setup      = psel && !penable;
   assign wr         = psel && penable && pready && pwrite;
   assign wr_ctrl    = wr && (paddr == TEC_OFF_CTRL);
   assign preload_wr = wr && (paddr == TEC_OFF_PRELOAD);

   always_comb begin
      case (paddr)
         TEC_OFF_CTRL, TEC_OFF_PRELOAD, TEC_OFF_COUNT,
         TEC_OFF_STATUS, TEC_OFF_MASK, TEC_OFF_CONFIG: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= setup;
         pslverr <= setup && !mapped;
      end
   end

   // read data is captured in the setup cycle, one cycle before completion
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup) begin
         case (paddr)
            TEC_OFF_CTRL:    prdata <= {24'h00_0000, ctrl_q}; // R18
            TEC_OFF_PRELOAD: prdata <= {24'h00_0000, preload_q};
            TEC_OFF_COUNT:   prdata <= {24'h00_0000, count_q};
            TEC_OFF_STATUS:  prdata <= {30'h0000_0000, status_q};
            TEC_OFF_MASK:    prdata <= {30'h0000_0000, mask_q};
            TEC_OFF_CONFIG:  prdata <= {31'h0000_0000, cfg_div4_q};
            default:         prdata <= 32'h0000_0000;
         endcase
      end
   end

   // a software write beats the automatic run clear at capture end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= TEC_CTRL_RST; // R18
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[7:0] & TEC_CTRL_WMASK; // R18
      end else if (cap_done) begin
         ctrl_q[TEC_RUN_BIT] <= 1'b0; // R4
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preload_q <= TEC_PRELOAD_RST;
      end else if (preload_wr) begin
         preload_q <= pwdata[7:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_q     <= '0;
         cfg_div4_q <= 1'b0;
      end else if (wr && (paddr == TEC_OFF_MASK)) begin
         mask_q <= pwdata[TEC_ST_W-1:0];
      end else if (wr && (paddr == TEC_OFF_CONFIG)) begin
         cfg_div4_q <= pwdata[TEC_CFG_DIV4];
      end
   end

   // two-flop synchroniser; edges are taken only past the second flop
   // reset to the pull-high idle level so that release brings no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_q    <= 1'b1;
         sync2_q    <= 1'b1;
         pin_prev_q <= 1'b1;
      end else begin
         sync1_q    <= ext_timer_pin; // R17
         sync2_q    <= sync1_q;
         pin_prev_q <= sync2_q;
      end
   end

   assign pin_rise  = sync2_q && !pin_prev_q; // R17
   assign pin_fall  = !sync2_q && pin_prev_q; // R17
   assign ev_edge   = edge_sel ? pin_fall : pin_rise; // R3
   assign pwc_start = edge_sel ? pin_rise : pin_fall; // R4
   assign pwc_stop  = edge_sel ? pin_fall : pin_rise; // R4
   assign cap_done  = (pwc_q == TEC_PWC_MEAS) && pwc_stop && run && (mode == TEC_MODE_PWC);

   // single-shot pulse capture: arm, count between edges, then stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwc_q <= TEC_PWC_IDLE;
      end else if (!run || (mode != TEC_MODE_PWC)) begin
         pwc_q <= TEC_PWC_IDLE;
      end else begin
         case (pwc_q)
            TEC_PWC_IDLE:  pwc_q <= TEC_PWC_ARMED;
            TEC_PWC_ARMED: pwc_q <= pwc_start ? TEC_PWC_MEAS : TEC_PWC_ARMED; // R4
            TEC_PWC_MEAS:  pwc_q <= pwc_stop ? TEC_PWC_IDLE : TEC_PWC_MEAS; // R4
            default:       pwc_q <= TEC_PWC_IDLE;
         endcase
      end
   end

   // the internal clock is stopped in sleep; only event counting goes on
   assign psc_active = run && !cpu_sleep &&
                       ((mode == TEC_MODE_TIMER) || (pwc_q == TEC_PWC_MEAS)); // R7

   tec_prescaler u_psc (
      .pclk     (pclk),
      .presetn  (presetn),
      .src_div4 (cfg_div4_q),
      .psc_sel  (ctrl_q[TEC_PSC_HI:0]),
      .active   (psc_active),
      .tick     (tick)
   );

   always_comb begin
      case (mode)
         TEC_MODE_EVENT: inc = run && ev_edge; // R6 R12 R13
         TEC_MODE_TIMER: inc = run && tick && !cpu_sleep; // R8
         TEC_MODE_PWC:   inc = run && tick && (pwc_q == TEC_PWC_MEAS);
         TEC_MODE_NONE:  inc = 1'b0; // R19
         default:        inc = 1'b0;
      endcase
   end

   assign ovf = inc && (count_q == TEC_CNT_FULL); // R15

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= TEC_CNT_RST;
      end else if (preload_wr && !run) begin
         count_q <= pwdata[7:0]; // R16
      end else if (ovf) begin
         count_q <= preload_wr ? pwdata[7:0] : preload_q; // R9 R16
      end else if (inc) begin
         count_q <= count_q + 8'h01; // R2 R15
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   assign st_set = {cap_done, ovf}; // R9
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_q <= '0;
      end else if (wr && (paddr == TEC_OFF_STATUS)) begin
         status_q <= (status_q & ~pwdata[TEC_ST_W-1:0]) | st_set;
      end else begin
         status_q <= status_q | st_set;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_irq <= 1'b0;
         wake_req  <= 1'b0;
      end else begin
         timer_irq <= |(status_q & mask_q); // R11
         wake_req  <= cpu_sleep && |(status_q & mask_q); // R10 R13
      end
   end

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   none_hold_a: assert property ((mode == TEC_MODE_NONE) && !preload_wr // R19
      |=> $stable(count_q) && !status_q[TEC_ST_OVF] || $past(status_q[TEC_ST_OVF]))
      else $error("counter moved with no mode");
   run_halt_a: assert property (!run && !preload_wr |=> $stable(count_q)) // R2
      else $error("stopped counter changed");
   mode_decode_a: assert property (inc |-> mode != TEC_MODE_NONE) // R1
      else $error("count step with no mode");
   event_step_a: assert property ((mode == TEC_MODE_EVENT) && run && ev_edge // R3
      && !preload_wr && (count_q != TEC_CNT_FULL) |=> count_q == $past(count_q) + 8'h01)
      else $error("event edge not counted");
   pin_only_a: assert property ((mode == TEC_MODE_EVENT) && inc |-> ev_edge) // R6 R12
      else $error("event count without pin edge");
   timer_tick_a: assert property ((mode == TEC_MODE_TIMER) && inc |-> tick) // R8
      else $error("timer count without tick");
   ovf_reload_a: assert property (ovf && !preload_wr // R9
      |=> count_q == $past(preload_q) && status_q[TEC_ST_OVF])
      else $error("overflow did not reload or flag");
   full_only_a: assert property ($rose(status_q[TEC_ST_OVF]) |-> $past(count_q) == TEC_CNT_FULL) // R15
      else $error("overflow below full count");
   stop_load_a: assert property (preload_wr && !run |=> count_q == $past(pwdata[7:0])) // R16
      else $error("stopped preload write not loaded");
   run_load_a: assert property (preload_wr && run && !inc |=> $stable(count_q)) // R16
      else $error("running preload write reached counter");
   irq_gate_a: assert property (status_q[TEC_ST_OVF] && !mask_q[TEC_ST_OVF] // R11
      && !(status_q[TEC_ST_CAP] && mask_q[TEC_ST_CAP]) |=> !timer_irq)
      else $error("masked overflow raised irq");
   irq_set_a: assert property (status_q[TEC_ST_OVF] && mask_q[TEC_ST_OVF] |=> timer_irq) // R11
      else $error("enabled overflow gave no irq");
   sleep_count_a: assert property ((mode == TEC_MODE_EVENT) && run && ev_edge // R13
      && cpu_sleep |-> inc) else $error("event lost in sleep");
   wake_a: assert property (cpu_sleep && (status_q & mask_q) != '0 |=> wake_req) // R10
      else $error("no wake request on pending overflow");
   edge_once_a: assert property (pin_rise |=> !pin_rise) // R17
      else $error("one pin edge seen twice");
   bit5_zero_a: assert property ((ctrl_q & ~TEC_CTRL_WMASK) == 8'h00) // R18
      else $error("reserved control bit set");
   cap_stop_a: assert property (cap_done && !wr_ctrl // R4
      |=> !run && status_q[TEC_ST_CAP] && (pwc_q == TEC_PWC_IDLE))
      else $error("capture end did not stop");
   pwc_start_a: assert property ((pwc_q == TEC_PWC_ARMED) && pwc_start && run // R4
      && (mode == TEC_MODE_PWC) |=> pwc_q == TEC_PWC_MEAS)
      else $error("capture start edge missed");
   pwc_count_a: assert property ((mode == TEC_MODE_PWC) && inc |-> pwc_q == TEC_PWC_MEAS) // R4
      else $error("capture counted outside pulse");
   irq_follow_a: assert property ((status_q & mask_q) == '0 |=> !timer_irq) // R11
      else $error("irq without enabled status");
   wake_sleep_a: assert property (!cpu_sleep |=> !wake_req) // R10
      else $error("wake request while awake");
   fall_once_a: assert property (pin_fall |=> !pin_fall) // R17
      else $error("one falling edge seen twice");

   event_ovf_c: cover property ((mode == TEC_MODE_EVENT) && ovf);
   timer_ovf_c: cover property ((mode == TEC_MODE_TIMER) && ovf);
   capture_c:   cover property (cap_done);
   wake_c:      cover property (cpu_sleep && $rose(wake_req));
   capture_hi_c: cover property (cap_done && edge_sel);
endmodule

/* File: hdl/tec_pkg.sv */
// constants, field layout and state types of the 8-bit timer/event counter
// assumes a byte-addressed apb slave with 32-bit data and an 8-bit address
package tec_pkg;
   // register byte offsets
   localparam logic [7:0] TEC_OFF_CTRL    = 8'h00;
   localparam logic [7:0] TEC_OFF_PRELOAD = 8'h04;
   localparam logic [7:0] TEC_OFF_COUNT   = 8'h08;
   localparam logic [7:0] TEC_OFF_STATUS  = 8'h0c;
   localparam logic [7:0] TEC_OFF_MASK    = 8'h10;
   localparam logic [7:0] TEC_OFF_CONFIG  = 8'h14;

   // timer_control field positions
   localparam int TEC_MODE_HI  = 7;
   localparam int TEC_MODE_LO  = 6;
   localparam int TEC_RUN_BIT  = 4;
   localparam int TEC_EDGE_BIT = 3;
   localparam int TEC_PSC_HI   = 2;

   localparam logic [7:0] TEC_CTRL_RST   = 8'h08;
   localparam logic [7:0] TEC_CTRL_WMASK = 8'hdf;
   localparam logic [7:0] TEC_PRELOAD_RST = 8'h00;
   localparam logic [7:0] TEC_CNT_FULL   = 8'hff;
   localparam logic [7:0] TEC_CNT_RST    = 8'h00;

   // status / mask layout
   localparam int TEC_ST_W   = 2;
   localparam int TEC_ST_OVF = 0;
   localparam int TEC_ST_CAP = 1;
   localparam int TEC_CFG_DIV4 = 0;

   // prescaler structure
   localparam int         TEC_PSC_W      = 7;
   localparam logic [1:0] TEC_PREDIV_MAX = 2'h3;

   typedef enum logic [1:0] {
      TEC_MODE_NONE  = 2'b00,
      TEC_MODE_EVENT = 2'b01,
      TEC_MODE_TIMER = 2'b10,
      TEC_MODE_PWC   = 2'b11
   } tec_mode_t;

   typedef enum logic [1:0] {
      TEC_PWC_IDLE  = 2'b00,
      TEC_PWC_ARMED = 2'b01,
      TEC_PWC_MEAS  = 2'b11
   } tec_pwc_t;
endpackage

/* File: hdl/tec_prescaler.sv */
// internal timer clock source and power-of-two prescaler, one tick per period
// assumes inputs from logic on pclk; tick is a one-cycle registered pulse
module tec_prescaler
   import tec_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       src_div4,
   input  wire logic [2:0] psc_sel,
   input  wire logic       active,
   output logic            tick
);
   logic [1:0]           pre_q;
   logic [TEC_PSC_W-1:0] div_q;
   logic [TEC_PSC_W-1:0] mask;
   logic                 base;
   logic                 hit;

   // base rate is pclk or pclk/4
   assign base = !src_div4 || (pre_q == TEC_PREDIV_MAX); // R7
   // the prescaled clock falls once every 2**psc_sel base ticks
   assign mask = ~({TEC_PSC_W{1'b1}} << psc_sel); // R5
   assign hit  = base && ((div_q & mask) == mask); // R5

   // restarting from zero keeps the first period after enable a full one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= 2'h0;
      end else if (!active) begin
         pre_q <= 2'h0;
      end else begin
         pre_q <= pre_q + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
      end else if (!active) begin
         div_q <= '0;
      end else if (base) begin
         div_q <= div_q + 7'h01;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 1'b0;
      end else begin
         tick <= active && hit;
      end
   end

   div4_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
      tick && src_div4 |=> !tick) else $error("div4 source ticked twice in a row");
   psc_gap_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
      tick && (psc_sel != 3'h0) |=> !tick) else $error("prescaler did not divide");
endmodule

/* File: verification/tec_pulse_src.sv */
// far-side model: a pulse source on the external timer pin
// assumes start is a one-cycle request on pclk; the pin idles high (pull-high)
module tec_pulse_src (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       start,
   input  wire logic [7:0] n_pulse,
   input  wire logic [7:0] half,
   output logic            pin,
   output logic            busy
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [8:0] left_q;
   logic [7:0] tmr_q;

   // pin is only ever driven toward the block, never read back from it
   // each pulse is a low phase then a high phase, so it ends at the idle level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin    <= 1'b1;
         busy   <= 1'b0;
         left_q <= '0;
         tmr_q  <= '0;
      end else if (start && !busy) begin
         busy   <= 1'b1;
         left_q <= {n_pulse, 1'b0};
         tmr_q  <= half;
      end else if (busy) begin
         if (tmr_q == 8'h01) begin
            pin    <= ~pin;
            tmr_q  <= half;
            left_q <= left_q - 9'h001;
            if (left_q == 9'h001) begin
               busy <= 1'b0;
            end
         end else begin
            tmr_q <= tmr_q - 8'h01;
         end
      end
   end
endmodule

/* File: verification/tec_timer_tb_top.sv */
// self-checking bench for the timer/event counter, driven over apb
// assumes the register map of tec_pkg and one pclk domain
module tec_timer_tb_top
   import tec_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int LIMIT = 40000;

   logic        pclk, presetn, psel, penable, pwrite, cpu_sleep;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, timer_irq, wake_req, pin, p_start, p_busy;
   logic [7:0]  p_n, p_half;
   int          miscompares, n_compared, cycles;

   tec_timer i_tec_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ext_timer_pin(pin), .cpu_sleep(cpu_sleep),
      .timer_irq(timer_irq), .wake_req(wake_req));

   tec_pulse_src i_tec_pulse_src (.pclk(pclk), .presetn(presetn), .start(p_start),
      .n_pulse(p_n), .half(p_half), .pin(pin), .busy(p_busy));

   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic conclude();
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // a hang is cut short here and still reaches the single verdict
   always @(posedge pclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
      n_compared++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask

   // each transfer starts one edge after entry so release and next setup never collide
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q       = prdata;
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic        e;
      apb(1'b0, a, 32'h0, rd, e);
      chk(rd, exp);
   endtask

   task automatic pulses(input logic [7:0] n, input logic [7:0] h);
      p_n     <= n;
      p_half  <= h;
      p_start <= 1'b1;
      @(posedge pclk);
      p_start <= 1'b0;
      @(posedge pclk);
      while (p_busy) @(posedge pclk);
      repeat (8) @(posedge pclk);
   endtask

   initial begin
      logic        e;
      logic [31:0] held;
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
      pwdata = 32'h0; cpu_sleep = 1'b0; p_start = 1'b0; p_n = 8'h00; p_half = 8'h01;
      miscompares = 0; n_compared = 0; cycles = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(TEC_OFF_CTRL, 32'h08);
      rd_chk(TEC_OFF_COUNT, 32'h00);
      wr(TEC_OFF_CTRL, 32'hff);
      rd_chk(TEC_OFF_CTRL, 32'hdf);
      apb(1'b0, 8'h18, 32'h0, rd, e);
      chk({rd[30:0], e}, 32'h1);
      wr(TEC_OFF_CTRL, 32'h17);
      repeat (50) @(posedge pclk);
      rd_chk(TEC_OFF_COUNT, 32'h00);
      rd_chk(TEC_OFF_STATUS, 32'h0);
      wr(TEC_OFF_CTRL, 32'h07);
      wr(TEC_OFF_PRELOAD, 32'hf0);
      rd_chk(TEC_OFF_COUNT, 32'hf0);
      // prescaler ratios: 40 ticks each, small slack for bus latency
      for (int k = 0; k < 8; k++) begin
         wr(TEC_OFF_PRELOAD, 32'h0);
         wr(TEC_OFF_CTRL, 32'h90 | k);
         repeat (40 << k) @(posedge pclk);
         wr(TEC_OFF_CTRL, 32'h80 | k);
         apb(1'b0, TEC_OFF_COUNT, 32'h0, rd, e);
         chk_rng(rd, 32'd38, 32'd43);
      end
      held = rd;
      repeat (20) @(posedge pclk);
      rd_chk(TEC_OFF_COUNT, held);
      wr(TEC_OFF_CONFIG, 32'h1);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_CTRL, 32'h91);
      repeat (320) @(posedge pclk);
      wr(TEC_OFF_CTRL, 32'h81);
      apb(1'b0, TEC_OFF_COUNT, 32'h0, rd, e);
      chk_rng(rd, 32'd38, 32'd42);
      wr(TEC_OFF_CONFIG, 32'h0);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_CTRL, 32'h97);
      wr(TEC_OFF_PRELOAD, 32'h55);
      apb(1'b0, TEC_OFF_COUNT, 32'h0, rd, e);
      chk_rng(rd, 32'h0, 32'h2);
      wr(TEC_OFF_CTRL, 32'h80);
      wr(TEC_OFF_PRELOAD, 32'hfa);
      wr(TEC_OFF_CTRL, 32'h90);
      repeat (20) @(posedge pclk);
      wr(TEC_OFF_CTRL, 32'h80);
      rd_chk(TEC_OFF_STATUS, 32'h1);
      chk({31'h0, timer_irq}, 32'h0);
      wr(TEC_OFF_MASK, 32'h1);
      repeat (3) @(posedge pclk);
      chk({31'h0, timer_irq}, 32'h1);
      wr(TEC_OFF_STATUS, 32'h1);
      repeat (3) @(posedge pclk);
      chk({31'h0, timer_irq}, 32'h0);
      rd_chk(TEC_OFF_STATUS, 32'h0);
      wr(TEC_OFF_CTRL, 32'h48);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_CTRL, 32'h57);
      pulses(8'd5, 8'd4);
      rd_chk(TEC_OFF_COUNT, 32'h05);
      wr(TEC_OFF_CTRL, 32'h4f);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_CTRL, 32'h5f);
      cpu_sleep <= 1'b1;
      pulses(8'd7, 8'd3);
      rd_chk(TEC_OFF_COUNT, 32'h07);
      wr(TEC_OFF_CTRL, 32'h4f);
      wr(TEC_OFF_PRELOAD, 32'hfe);
      wr(TEC_OFF_CTRL, 32'h5f);
      pulses(8'd3, 8'd3);
      chk({30'h0, wake_req, timer_irq}, 32'h3);
      rd_chk(TEC_OFF_COUNT, 32'hff);
      cpu_sleep <= 1'b0;
      wr(TEC_OFF_CTRL, 32'hc0);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_STATUS, 32'h3);
      wr(TEC_OFF_CTRL, 32'hd0);
      pulses(8'd1, 8'd20);
      rd_chk(TEC_OFF_CTRL, 32'hc0);
      apb(1'b0, TEC_OFF_COUNT, 32'h0, rd, e);
      chk_rng(rd, 32'd17, 32'd23);
      held = rd;
      rd_chk(TEC_OFF_STATUS, 32'h2);
      pulses(8'd1, 8'd20);
      rd_chk(TEC_OFF_COUNT, held);
      wr(TEC_OFF_STATUS, 32'h2);
      wr(TEC_OFF_PRELOAD, 32'h0);
      wr(TEC_OFF_CTRL, 32'hd8);
      pulses(8'd2, 8'd20);
      rd_chk(TEC_OFF_CTRL, 32'hc8);
      apb(1'b0, TEC_OFF_COUNT, 32'h0, rd, e);
      chk_rng(rd, 32'd17, 32'd23);
      rd_chk(TEC_OFF_STATUS, 32'h2);
      conclude();
   end
endmodule
